// *** design/perf_event_decoder.sv ***
`include "perf_event_defines.svh"

module perf_event_decoder #(
  parameter int CNT_W = 48,
  parameter int OCC_W = 6,
  parameter int UOP_W = 3,
  parameter int INC_W = 8
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    sel_wr,
  input  wire perf_event_pkg::sel_code_t sel_event_code,
  input  wire perf_event_pkg::sel_code_t sel_unit_mask,
  input  wire logic [7:0]              sel_cmask,
  input  wire logic                    sel_edge,
  input  wire logic                    count_enable,
  input  wire logic                    count_clear,
  input  wire logic                    thread_unhalted,
  input  wire logic [1:0]              priv_level,
  input  wire logic                    sched_station_empty,
  input  wire logic [OCC_W-1:0]        offcore_data_rd_cnt,
  input  wire logic [OCC_W-1:0]        offcore_code_rd_cnt,
  input  wire logic [OCC_W-1:0]        offcore_own_rd_cnt,
  input  wire logic [OCC_W-1:0]        offcore_all_data_rd_cnt,
  input  wire logic                    split_uncached_lock,
  input  wire logic                    data_cache_lock,
  input  wire logic                    decode_queue_empty,
  input  wire logic [UOP_W-1:0]        legacy_path_uops,
  input  wire logic [UOP_W-1:0]        uop_cache_uops,
  input  wire logic                    microcode_sequencer_busy,
  input  wire logic                    instr_cache_miss,
  input  wire logic                    instr_tlb_walk_miss,
  output logic [CNT_W-1:0]             count_q,
  output logic [INC_W-1:0]             increment_q,
  output logic                         select_valid_q,
  output perf_event_pkg::event_src_t   active_src_q,
  output logic                         cond_q,
  output logic                         count_wrap_q
);

  import perf_event_pkg::*;

  if (CNT_W < 16) begin
    $error("perf_event_decoder: CNT_W too small");
  end
  if (OCC_W > INC_W) begin
    $error("perf_event_decoder: OCC_W exceeds INC_W");
  end
  if (UOP_W + 2 > INC_W) begin
    $error("perf_event_decoder: four uop classes overflow INC_W");
  end

  sel_code_t        event_code_q;
  sel_code_t        unit_mask_q;
  logic [7:0]       cmask_q;
  logic             edge_q;
  logic             restart_q;
  event_src_t       src_d;
  logic             valid_d;
  logic [INC_W-1:0] raw_inc_d;
  logic [INC_W-1:0] raw_inc_q;
  logic [INC_W-1:0] thr_inc;
  logic             thr_cond;
  logic [INC_W-1:0] offcore_inc;
  logic [INC_W-1:0] path_inc;
  logic [INC_W-1:0] class_inc [4];
  logic [CNT_W:0]   count_sum;
  logic             priv_zero;

  // Selector held locally so the decode is stable between writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      event_code_q <= `RST_EVENT_CODE;
      unit_mask_q  <= `RST_UNIT_MASK;
      cmask_q      <= `RST_CMASK;
      edge_q       <= `RST_EDGE;
    end else if (sel_wr) begin
      event_code_q <= sel_event_code;
      unit_mask_q  <= sel_unit_mask;
      cmask_q      <= sel_cmask;
      edge_q       <= sel_edge;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= sel_wr;
    end
  end

  assign priv_zero = (priv_level == `PRIV_LEVEL_ZERO);

  // Event code selects the source; unit mask qualifies it
  always_comb begin
    src_d   = SRC_NONE;
    valid_d = 1'b0;
    case (event_code_q)
      `EVT_PRIV_CYCLES: begin
        if (unit_mask_q == `UM_PRIV_ZERO) begin
          src_d   = SRC_PRIV_ZERO;
          valid_d = 1'b1;
        end else if (unit_mask_q == `UM_PRIV_NONZERO) begin
          src_d   = SRC_PRIV_NONZERO;
          valid_d = 1'b1;
        end
      end
      `EVT_SCHED_EVENTS: begin
        if (unit_mask_q == `UM_SCHED_EMPTY) begin
          src_d   = SRC_SCHED_EMPTY;
          valid_d = 1'b1;
        end
      end
      `EVT_OFFCORE_OUTST: begin
        if (unit_mask_q == `UM_OFF_DATA_RD || unit_mask_q == `UM_OFF_CODE_RD ||
            unit_mask_q == `UM_OFF_OWN_RD || unit_mask_q == `UM_OFF_ALL_DATA_RD) begin
          src_d   = SRC_OFFCORE;
          valid_d = 1'b1;
        end
      end
      `EVT_LOCK_CYCLES: begin
        if (unit_mask_q == `UM_LOCK_SPLIT_UC) begin
          src_d   = SRC_LOCK_SPLIT;
          valid_d = 1'b1;
        end else if (unit_mask_q == `UM_LOCK_DATA_CACHE) begin
          src_d   = SRC_LOCK_DATA;
          valid_d = 1'b1;
        end
      end
      `EVT_DECODE_QUEUE: begin
        if (unit_mask_q == `UM_DQ_EMPTY) begin
          src_d   = SRC_DQ_EMPTY;
          valid_d = 1'b1;
        end else if (unit_mask_q != 8'h00 &&
                     (unit_mask_q & ~`UM_PATH_FIELD) == 8'h00) begin
          src_d   = SRC_UOP_PATHS;
          valid_d = 1'b1;
        end
      end
      `EVT_INSTR_CACHE: begin
        if (unit_mask_q == `UM_INSTR_CACHE_MISS) begin
          src_d   = SRC_ICACHE_MISS;
          valid_d = 1'b1;
        end
      end
      `EVT_INSTR_TLB: begin
        if (unit_mask_q == `UM_ITLB_WALK) begin
          src_d   = SRC_ITLB_WALK;
          valid_d = 1'b1;
        end
      end
      default: begin
        src_d   = SRC_NONE;
        valid_d = 1'b0;
      end
    endcase
  end

  // Offcore occupancy; only meaningful with one thread per core
  always_comb begin
    case (unit_mask_q)
      `UM_OFF_DATA_RD:     offcore_inc = INC_W'(offcore_data_rd_cnt);
      `UM_OFF_CODE_RD:     offcore_inc = INC_W'(offcore_code_rd_cnt);
      `UM_OFF_OWN_RD:      offcore_inc = INC_W'(offcore_own_rd_cnt);
      `UM_OFF_ALL_DATA_RD: offcore_inc = INC_W'(offcore_all_data_rd_cnt);
      default:             offcore_inc = '0;
    endcase
  end

  // Four delivery classes: path x sequencer state, each gated by its mask bit
  for (genvar i = 0; i < 4; i++) begin : g_class
    localparam int MASK_BIT = (i == 0) ? `UM_BIT_LEGACY :
                              (i == 1) ? `UM_BIT_SEQ_LEGACY :
                              (i == 2) ? `UM_BIT_CACHE : `UM_BIT_SEQ_CACHE;
    localparam bit FROM_CACHE = (i >= 2);
    localparam bit SEQ_BUSY   = (i % 2 == 1);
    always_comb begin
      if (unit_mask_q[MASK_BIT] && (microcode_sequencer_busy == SEQ_BUSY)) begin
        class_inc[i] = FROM_CACHE ? INC_W'(uop_cache_uops)
                                  : INC_W'(legacy_path_uops);
      end else begin
        class_inc[i] = '0;
      end
    end
  end

  // OR-combined masks simply add their classes; no overlap between classes
  assign path_inc = class_inc[0] + class_inc[1] + class_inc[2] + class_inc[3];

  always_comb begin
    raw_inc_d = '0;
    case (src_d)
      SRC_PRIV_ZERO: begin
        raw_inc_d = INC_W'(thread_unhalted & priv_zero);
      end
      SRC_PRIV_NONZERO: begin
        raw_inc_d = INC_W'(thread_unhalted & ~priv_zero);
      end
      SRC_SCHED_EMPTY: begin
        raw_inc_d = INC_W'(sched_station_empty);
      end
      SRC_OFFCORE: begin
        raw_inc_d = offcore_inc;
      end
      SRC_LOCK_SPLIT: begin
        raw_inc_d = INC_W'(split_uncached_lock);
      end
      SRC_LOCK_DATA: begin
        raw_inc_d = INC_W'(data_cache_lock);
      end
      SRC_DQ_EMPTY: begin
        raw_inc_d = INC_W'(decode_queue_empty);
      end
      SRC_UOP_PATHS: begin
        raw_inc_d = path_inc;
      end
      SRC_ICACHE_MISS: begin
        raw_inc_d = INC_W'(instr_cache_miss);
      end
      SRC_ITLB_WALK: begin
        raw_inc_d = INC_W'(instr_tlb_walk_miss);
      end
      default: begin
        raw_inc_d = '0;
      end
    endcase
  end

  // One stage of registering keeps the wide adder off the decode path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      raw_inc_q <= '0;
    end else begin
      raw_inc_q <= raw_inc_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      select_valid_q <= 1'b0;
      active_src_q   <= SRC_NONE;
    end else begin
      select_valid_q <= valid_d;
      active_src_q   <= src_d;
    end
  end

  perf_threshold_edge #(
    .INC_W (INC_W)
  ) u_thresh (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .restart (restart_q),
    .raw_inc (raw_inc_q),
    .cmask   (cmask_q),
    .edge_en (edge_q),
    .out_inc (thr_inc),
    .cond    (thr_cond)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      increment_q <= '0;
      cond_q      <= 1'b0;
    end else begin
      increment_q <= thr_inc;
      cond_q      <= thr_cond;
    end
  end

  assign count_sum = {1'b0, count_q} + {{(CNT_W+1-INC_W){1'b0}}, thr_inc};

  // Clear takes priority over counting; a low enable freezes the count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (count_clear) begin
      count_q <= '0;
    end else if (count_enable) begin
      count_q <= count_sum[CNT_W-1:0];
    end
  end

  // Wrap is sticky; a carry in the clearing cycle still sets it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_wrap_q <= 1'b0;
    end else begin
      count_wrap_q <= (count_enable & count_sum[CNT_W]) |
                      (count_wrap_q & ~count_clear);
    end
  end

endmodule

// *** design/perf_threshold_edge.sv ***
module perf_threshold_edge #(
  parameter int INC_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             restart,
  input  wire logic [INC_W-1:0] raw_inc,
  input  wire logic [7:0]       cmask,
  input  wire logic             edge_en,
  output logic      [INC_W-1:0] out_inc,
  output logic                  cond
);

  logic             cond_prev_q;
  logic [INC_W+7:0] inc_wide;
  logic [INC_W+7:0] cmask_wide;

  assign inc_wide   = {8'h00, raw_inc};
  assign cmask_wide = {{INC_W{1'b0}}, cmask};

  // Zero threshold: any activity is the condition, so edge mode still works
  always_comb begin
    if (cmask == 8'h00) begin
      cond = (raw_inc != '0);
    end else begin
      cond = (inc_wide >= cmask_wide);
    end
  end

  always_comb begin
    if (edge_en) begin
      out_inc = {{(INC_W-1){1'b0}}, cond & ~cond_prev_q};
    end else if (cmask != 8'h00) begin
      out_inc = {{(INC_W-1){1'b0}}, cond};
    end else begin
      out_inc = raw_inc;
    end
  end

  // History dropped on reprogramming so a stale level gives no false edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cond_prev_q <= 1'b0;
    end else if (restart) begin
      cond_prev_q <= 1'b0;
    end else begin
      cond_prev_q <= cond;
    end
  end

endmodule

// *** inc/perf_event_defines.svh ***
// Operation
// - 5CH/01H counts unhalted privilege-zero cycles, edge entries
// - 5CH/02H counts unhalted nonzero-privilege cycles
// - 5EH/01H counts scheduling station empty cycles
// - 60H adds selected outstanding offcore request occupancy
// - 63H/01H counts split or uncached lock cycles
// - 63H/02H counts data cache lock cycles
// - 79H/02H counts decode queue empty cycles
// - 79H/04H adds legacy path delivered micro-ops
// - 79H/08H adds micro-op cache delivered micro-ops
// - 79H/10H adds cache micro-ops while sequencer busy
// - 79H/20H adds legacy micro-ops while sequencer busy
// - 79H/30H adds all sequencer micro-ops
// - 79H/18H counts micro-op cache delivering cycles
// - 79H/24H counts legacy path delivering cycles
// - Path and sequencer masks combine by OR
// - 79H/3CH adds micro-ops from every path
// - 80H/02H counts instruction cache misses
// - 85H/01H counts instruction TLB walk misses
`ifndef PERF_EVENT_DEFINES_SVH
`define PERF_EVENT_DEFINES_SVH

`define EVT_PRIV_CYCLES      8'h5C
`define EVT_SCHED_EVENTS     8'h5E
`define EVT_OFFCORE_OUTST    8'h60
`define EVT_LOCK_CYCLES      8'h63
`define EVT_DECODE_QUEUE     8'h79
`define EVT_INSTR_CACHE      8'h80
`define EVT_INSTR_TLB        8'h85

`define UM_PRIV_ZERO         8'h01
`define UM_PRIV_NONZERO      8'h02
`define UM_SCHED_EMPTY       8'h01
`define UM_OFF_DATA_RD       8'h01
`define UM_OFF_CODE_RD       8'h02
`define UM_OFF_OWN_RD        8'h04
`define UM_OFF_ALL_DATA_RD   8'h08
`define UM_LOCK_SPLIT_UC     8'h01
`define UM_LOCK_DATA_CACHE   8'h02
`define UM_DQ_EMPTY          8'h02
`define UM_PATH_FIELD        8'h3C
`define UM_INSTR_CACHE_MISS  8'h02
`define UM_ITLB_WALK         8'h01

`define UM_BIT_LEGACY        2
`define UM_BIT_CACHE         3
`define UM_BIT_SEQ_CACHE     4
`define UM_BIT_SEQ_LEGACY    5

`define PRIV_LEVEL_ZERO      2'h0

`define RST_EVENT_CODE       8'h00
`define RST_UNIT_MASK        8'h00
`define RST_CMASK            8'h00
`define RST_EDGE             1'b0

`endif

// *** inc/perf_event_pkg.sv ***
package perf_event_pkg;

  typedef enum logic [3:0] {
    SRC_NONE,
    SRC_PRIV_ZERO,
    SRC_PRIV_NONZERO,
    SRC_SCHED_EMPTY,
    SRC_OFFCORE,
    SRC_LOCK_SPLIT,
    SRC_LOCK_DATA,
    SRC_DQ_EMPTY,
    SRC_UOP_PATHS,
    SRC_ICACHE_MISS,
    SRC_ITLB_WALK
  } event_src_t;

  typedef logic [7:0] sel_code_t;

endpackage

// *** verif/core_event_model.sv ***
module core_event_model (
  input  wire logic [31:0] rnd,
  input  wire logic        rstn,
  output logic             thread_unhalted,
  output logic [1:0]       priv_level,
  output logic             sched_station_empty,
  output logic [5:0]       offcore_data_rd_cnt,
  output logic [5:0]       offcore_code_rd_cnt,
  output logic [5:0]       offcore_own_rd_cnt,
  output logic [5:0]       offcore_all_data_rd_cnt,
  output logic             split_uncached_lock,
  output logic             data_cache_lock,
  output logic             decode_queue_empty,
  output logic [2:0]       legacy_path_uops,
  output logic [2:0]       uop_cache_uops,
  output logic             microcode_sequencer_busy,
  output logic             instr_cache_miss,
  output logic             instr_tlb_walk_miss
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] r;

  // Idle in reset so the pipe starts empty
  assign r = rstn ? rnd : 32'h00000000;
  assign {instr_tlb_walk_miss, instr_cache_miss, microcode_sequencer_busy} = r[9:7];
  assign {decode_queue_empty, data_cache_lock, split_uncached_lock} = r[6:4];
  assign {sched_station_empty, priv_level, thread_unhalted} = r[3:0];
  // Single thread, no sibling share in the queue counts
  assign offcore_data_rd_cnt = r[21:16];
  assign offcore_code_rd_cnt = r[27:22];
  assign offcore_own_rd_cnt = {r[31:28], r[1:0]};
  assign offcore_all_data_rd_cnt = r[9:4];
  // Four delivery slots per cycle at most
  assign legacy_path_uops = r[12:10] > 3'h4 ? 3'h4 : r[12:10];
  assign uop_cache_uops = r[15:13] > 3'h4 ? 3'h4 : r[15:13];
endmodule

// *** verif/perf_event_decoder_properties.sv ***
module perf_event_decoder_checker
  import perf_event_pkg::*;
#(
  parameter int CNT_W = 48,
  parameter int INC_W = 8
) (
  input wire logic             sys_clk,
  input wire logic             rstn,
  input wire logic             sel_wr,
  input wire sel_code_t        sel_event_code,
  input wire sel_code_t        sel_unit_mask,
  input wire logic [7:0]       sel_cmask,
  input wire logic             sel_edge,
  input wire logic             count_enable,
  input wire logic             count_clear,
  input wire logic [CNT_W-1:0] count_q,
  input wire logic [INC_W-1:0] increment_q,
  input wire logic             select_valid_q,
  input wire event_src_t       active_src_q,
  input wire logic             count_wrap_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_clear;
    count_clear |=> count_q == '0 &&
      count_wrap_q == ($past(count_enable) && $past(count_q) > ~CNT_W'(increment_q));
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");
  property p_hold;
    !count_enable && !count_clear |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");
  property p_add;
    count_enable && !count_clear |=> count_q == $past(count_q) + increment_q;
  endproperty
  a_add: assert property (p_add) else $error("count step differs from increment");
  property p_valid;
    select_valid_q == (active_src_q != SRC_NONE);
  endproperty
  a_valid: assert property (p_valid) else $error("valid and source disagree");
  property p_priv;
    (sel_wr && sel_event_code == 8'h5C && sel_unit_mask == 8'h01) ##1 !sel_wr
      |=> select_valid_q && active_src_q == SRC_PRIV_ZERO;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege select not decoded");
  property p_bad;
    (sel_wr && sel_event_code == 8'h79 && sel_unit_mask == 8'h40) ##1 !sel_wr
      |=> !select_valid_q && active_src_q == SRC_NONE;
  endproperty
  a_bad: assert property (p_bad) else $error("bad path mask accepted");
  property p_quiet;
    !select_valid_q [*3] |-> increment_q == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("increment on invalid select");
  property p_thresh;
    (sel_cmask != 8'h00) [*6] |-> increment_q <= 1;
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold increment above one");
  property p_edge;
    sel_edge [*8] |-> increment_q <= 1 && !(increment_q != 0 && $past(increment_q) != 0);
  endproperty
  a_edge: assert property (p_edge) else $error("edge mode counted twice");
endmodule

bind perf_event_decoder perf_event_decoder_checker #(
  .CNT_W(CNT_W),
  .INC_W(INC_W)
) u_checker (
  .sys_clk, .rstn, .sel_wr, .sel_event_code, .sel_unit_mask, .sel_cmask, .sel_edge,
  .count_enable, .count_clear, .count_q, .increment_q, .select_valid_q, .active_src_q,
  .count_wrap_q
);

// *** verif/perf_event_decoder_tb.sv ***
module perf_event_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import perf_event_pkg::*;

  localparam logic [31:0] TBL [31] = '{
    32'h5C010000, 32'h5C020000, 32'h5E010000, 32'h60010000, 32'h60020000, 32'h60040000,
    32'h60080000, 32'h60010100, 32'h63010000, 32'h63020000, 32'h79020000, 32'h79040000,
    32'h79080000, 32'h79100000, 32'h79200000, 32'h79300000, 32'h79180100, 32'h79180400,
    32'h79240100, 32'h79240400, 32'h793C0000, 32'h79140000, 32'h790C0000, 32'h80020000,
    32'h85010000, 32'h5C010001, 32'h79400000, 32'h79100101, 32'h79060000, 32'h79240001,
    32'h00000000};
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sel_wr = 1'b0;
  sel_code_t   sel_event_code = 8'h00;
  sel_code_t   sel_unit_mask = 8'h00;
  logic [7:0]  sel_cmask = 8'h00;
  logic        sel_edge = 1'b0;
  logic        count_enable = 1'b0;
  logic        count_clear = 1'b0;
  logic [31:0] lfsr_q = 32'h0000003B;
  logic        chk = 1'b0;
  logic        en_p = 1'b0;
  logic        clr_p = 1'b0;
  wire logic   thread_unhalted, sched_station_empty, split_uncached_lock, data_cache_lock;
  wire logic   decode_queue_empty, microcode_sequencer_busy, instr_cache_miss;
  wire logic   instr_tlb_walk_miss;
  wire logic [1:0] priv_level;
  wire logic [5:0] offcore_data_rd_cnt, offcore_code_rd_cnt, offcore_own_rd_cnt;
  wire logic [5:0] offcore_all_data_rd_cnt;
  wire logic [2:0] legacy_path_uops, uop_cache_uops;
  logic [47:0] count_q;
  logic [7:0]  increment_q;
  logic        select_valid_q, count_wrap_q, cond_q;
  event_src_t  active_src_q;
  int          mismatches = 0, compares = 0, prev_c = 0, p1 = 0, p2 = 0, q1 = 0, q2 = 0;
  longint      exp_cnt = 0;

  perf_event_decoder dut (
    .sys_clk, .rstn, .sel_wr, .sel_event_code, .sel_unit_mask, .sel_cmask, .sel_edge,
    .count_enable, .count_clear, .thread_unhalted, .priv_level, .sched_station_empty,
    .offcore_data_rd_cnt, .offcore_code_rd_cnt, .offcore_own_rd_cnt, .offcore_all_data_rd_cnt,
    .split_uncached_lock, .data_cache_lock, .decode_queue_empty, .legacy_path_uops,
    .uop_cache_uops, .microcode_sequencer_busy, .instr_cache_miss, .instr_tlb_walk_miss,
    .count_q, .increment_q, .select_valid_q, .active_src_q, .cond_q, .count_wrap_q);
  core_event_model core (
    .rnd(lfsr_q), .rstn, .thread_unhalted, .priv_level, .sched_station_empty,
    .offcore_data_rd_cnt, .offcore_code_rd_cnt, .offcore_own_rd_cnt, .offcore_all_data_rd_cnt,
    .split_uncached_lock, .data_cache_lock, .decode_queue_empty, .legacy_path_uops,
    .uop_cache_uops, .microcode_sequencer_busy, .instr_cache_miss, .instr_tlb_walk_miss);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic event_src_t decode(input logic [7:0] c, m, output int s);
    logic [3:0] sv;
    {sv, s} = {SRC_NONE, 32'h00000000};
    case ({c, m})
      16'h5C01: {sv, s} = {SRC_PRIV_ZERO, 32'(thread_unhalted && priv_level == 2'h0)};
      16'h5C02: {sv, s} = {SRC_PRIV_NONZERO, 32'(thread_unhalted && priv_level != 2'h0)};
      16'h5E01: {sv, s} = {SRC_SCHED_EMPTY, 32'(sched_station_empty)};
      16'h6001: {sv, s} = {SRC_OFFCORE, 32'(offcore_data_rd_cnt)};
      16'h6002: {sv, s} = {SRC_OFFCORE, 32'(offcore_code_rd_cnt)};
      16'h6004: {sv, s} = {SRC_OFFCORE, 32'(offcore_own_rd_cnt)};
      16'h6008: {sv, s} = {SRC_OFFCORE, 32'(offcore_all_data_rd_cnt)};
      16'h6301: {sv, s} = {SRC_LOCK_SPLIT, 32'(split_uncached_lock)};
      16'h6302: {sv, s} = {SRC_LOCK_DATA, 32'(data_cache_lock)};
      16'h7902: {sv, s} = {SRC_DQ_EMPTY, 32'(decode_queue_empty)};
      16'h8002: {sv, s} = {SRC_ICACHE_MISS, 32'(instr_cache_miss)};
      16'h8501: {sv, s} = {SRC_ITLB_WALK, 32'(instr_tlb_walk_miss)};
      default: if (c == 8'h79 && m[7:6] == 2'h0 && m[1:0] == 2'h0 && m[5:2] != 4'h0) begin
        sv = SRC_UOP_PATHS;
        // Busy steers each path into its sequencer class
        s = microcode_sequencer_busy ? (m[5] ? legacy_path_uops : 0) + (m[4] ? uop_cache_uops : 0)
          : (m[2] ? legacy_path_uops : 0) + (m[3] ? uop_cache_uops : 0);
      end
    endcase
    return event_src_t'(sv);
  endfunction

  task automatic cmp_num(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic cmp_src(input event_src_t e, input event_src_t g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error source expected %0d seen %0d", e, g);
    end
  endtask

  always @(negedge sys_clk) begin
    int s, c;
    event_src_t src;
    src = decode(sel_event_code, sel_unit_mask, s);
    c = sel_cmask != 8'h00 ? int'(s >= sel_cmask) : int'(s != 0);
    if (sel_cmask != 8'h00) s = c;
    if (sel_edge) s = int'(c != 0 && prev_c == 0);
    prev_c = c;
    exp_cnt = clr_p ? 0 : en_p ? exp_cnt + p2 : exp_cnt;
    if (chk) begin
      cmp_num("increment", p2, increment_q);
      cmp_num("count", exp_cnt, count_q);
      cmp_num("cond", q2, cond_q);
      cmp_num("wrap", 0, count_wrap_q);
      cmp_num("valid", src != SRC_NONE, select_valid_q);
      cmp_src(src, active_src_q);
    end
    p2 = p1;
    p1 = s;
    q2 = q1;
    q1 = c;
    en_p = count_enable;
    clr_p = count_clear;
  end

  task automatic step(input logic en);
    @(posedge sys_clk);
    #1;
    lfsr_q = lfsr(lfsr_q);
    count_enable = en & (lfsr_q[29] | lfsr_q[30]);
  endtask

  // Clear held while the new selector settles, so the count restarts at zero
  task automatic run(input logic [31:0] t);
    step(1'b0);
    sel_wr = 1'b1;
    {sel_event_code, sel_unit_mask, sel_cmask} = t[31:8];
    sel_edge = t[0];
    count_clear = 1'b1;
    step(1'b0);
    sel_wr = 1'b0;
    repeat (5) step(1'b0);
    count_clear = 1'b0;
    chk = 1'b1;
    repeat (60) step(1'b1);
    chk = 1'b0;
    $display("test %h done", t);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    foreach (TBL[i]) run(TBL[i]);
    test_done;
  end

  initial begin
    #100us;
    mismatches++;
    test_done;
  end
endmodule
